// ---- cgt_consts.svh ----
`ifndef CGT_CONSTS_SVH
`define CGT_CONSTS_SVH
// gear divide select codes
`define CGT_GEAR_DIV4 2'h0
`define CGT_GEAR_DIV2 2'h1
`define CGT_GEAR_DIV1 2'h2
`define CGT_GEAR_RSVD 2'h3
`define CGT_GEAR_RESET 2'h0
// last count of a gear period for each code
`define CGT_GEAR_LAST4 2'h3
`define CGT_GEAR_LAST2 2'h1
`define CGT_GEAR_LAST1 2'h0
// machine cycles of settling and of guard after a select change
`define CGT_GEAR_SETTLE_MC 2'h2
`define CGT_REF_GUARD_MC 2'h2
// low-frequency clock divided by four
`define CGT_LOW_LAST 2'h3
// divider geometry
`define CGT_DIV_STAGES 21
`define CGT_DIV_LOW_STAGES 8
`define CGT_PRESCALE_W 2
// instruction lengths in machine cycles
`define CGT_INSTR_MIN 4'h1
`define CGT_INSTR_SHORT_MAX 4'hA
`define CGT_INSTR_LONGEST 4'hD
`endif

// ---- cgt_pkg.sv ----
package cgt_pkg;
    // reference clock selector state
    typedef enum logic {
        CGT_REF_STEADY,
        CGT_REF_SWITCH
    } cgt_ref_state_type;
endpackage

// ---- cgt_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pins from outside the clock domain
module cgt_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // only the second stage is visible to other logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- cgt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cgt_consts.svh"
// How it works
// - reference switch waits for the new source edge; pause stays short.
// - old oscillator stopped within two machine cycles gives a reset.
// - reference select writes are ignored while slow select is one.
// - external enable high with port pins not oscillator gives a reset.
// - only a zero-to-one enable change starts the warm-up.
// - gear code 00 divides by four, 01 by two, 10 none; 11 reserved.
// - a new gear code takes effect at the first period end after a two-machine-cycle wait.
// - a gear change may stretch a period, never shorten one.
// - gear clock is a quarter of the reference after reset.
// - main clock is gear clock, or low clock over four when slow.
// - main switch completes later; stopping the running oscillator resets.
// - stage nine takes stage eight, or low clock over four.
// - slow mode stops the prescaler and divider stages one to eight.
// - prescaler and divider clear on reset and stop-mode warm-up end.
// - timing generator has selector, prescaler, 21 stages, cycle counter.
// - one machine cycle is one main system clock period.
// - instructions last one to ten, or thirteen, machine cycles.
// - reference select one picks external, zero internal; resets to zero.
// - an enable combination leaving the clock without oscillator resets.
module cgt_top #(
    parameter int DIV_STAGES = `CGT_DIV_STAGES,
    parameter int LOW_STAGES = `CGT_DIV_LOW_STAGES,
    parameter int PRESC_W = `CGT_PRESCALE_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_int_pin,
    input wire logic osc_ext_pin,
    input wire logic osc_low_pin,
    input wire logic int_osc_en,
    input wire logic ext_osc_en,
    input wire logic low_osc_en,
    input wire logic port_osc_pin_select,
    input wire logic slow_select,
    input wire logic stage9_slow_select,
    input wire logic ref_sel_wr,
    input wire logic ref_sel_wdata,
    input wire logic gear_sel_wr,
    input wire logic [1:0] gear_sel_wdata,
    input wire logic stop_warm_done,
    input wire logic instr_start,
    input wire logic [3:0] instr_len,
    output logic ref_sel_q,
    output logic ref_switching_q,
    output logic hf_ref_tick_q,
    output logic [1:0] gear_sel_q,
    output logic gear_tick_q,
    output logic main_tick_q,
    output logic main_is_slow_q,
    output logic [DIV_STAGES-1:0] divider_q,
    output logic warmup_start_int_q,
    output logic warmup_start_ext_q,
    output logic warmup_start_low_q,
    output logic sysclk_reset_req_q,
    output logic instr_last_q
);
    logic [2:0] pin_s;
    logic [2:0] pin_p_q;
    logic int_rise, ext_rise, low_rise, new_rise, ref_wr_ok;
    cgt_pkg::cgt_ref_state_type ref_state_q;
    logic [1:0] guard_q;
    logic int_en_p_q, ext_en_p_q, low_en_p_q;
    logic early_stop, all_stop, slow_dead, hf_dead, pin_bad, both_dead, fault;
    logic [1:0] gear_pend_q, gear_wait_q, gear_cnt_q, gear_last_cnt;
    logic gear_last, gear_tick_d, gear_apply, gear_wr_ok;
    logic [1:0] low_cnt_q;
    logic low_q4_d, main_tick_d;
    logic [PRESC_W-1:0] presc_q;
    logic presc_carry, s8_carry, s9_in, fast_run, len_ok;
    logic [3:0] mc_left_q;
    logic [2:0] pause_q;

    // oscillator pins come from other clocks
    cgt_sync2 #(.W(3)) pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in({osc_low_pin, osc_ext_pin, osc_int_pin}),
        .sync_out(pin_s)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_p_q <= 3'h0;
        end else begin
            pin_p_q <= pin_s;
        end
    end

    // rising edges of each oscillator, one pulse each
    assign int_rise = pin_s[0] & ~pin_p_q[0];
    assign ext_rise = pin_s[1] & ~pin_p_q[1];
    assign low_rise = pin_s[2] & ~pin_p_q[2];
    assign new_rise = ref_sel_q ? ext_rise : int_rise;

    // selection is refused in slow mode and during a switch in flight
    assign ref_wr_ok = ref_sel_wr && !slow_select &&
        (ref_state_q == cgt_pkg::CGT_REF_STEADY) &&
        (ref_sel_wdata != ref_sel_q);

    // reference selector: old edges are dropped the moment the select
    // moves, and the switch ends on the first edge of the new source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_sel_q <= 1'b0;
            ref_state_q <= cgt_pkg::CGT_REF_STEADY;
            ref_switching_q <= 1'b0;
        end else begin
            case (ref_state_q)
                cgt_pkg::CGT_REF_STEADY: begin
                    if (ref_wr_ok) begin
                        ref_sel_q <= ref_sel_wdata;
                        ref_state_q <= cgt_pkg::CGT_REF_SWITCH;
                        ref_switching_q <= 1'b1;
                    end
                end
                cgt_pkg::CGT_REF_SWITCH: begin
                    if (new_rise) begin
                        ref_state_q <= cgt_pkg::CGT_REF_STEADY;
                        ref_switching_q <= 1'b0;
                    end
                end
                default: ref_state_q <= cgt_pkg::CGT_REF_STEADY;
            endcase
        end
    end

    // reference tick only from the selected source, so no runt period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hf_ref_tick_q <= 1'b0;
            pause_q <= 3'h0;
        end else begin
            hf_ref_tick_q <= new_rise;
            if (!ref_switching_q) begin
                pause_q <= 3'h0;
            end else if (int_rise && pause_q != 3'h7) begin
                pause_q <= pause_q + 3'h1;
            end
        end
    end

    // guard window after a select change, counted in machine cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            guard_q <= 2'h0;
        end else if (ref_wr_ok) begin
            guard_q <= `CGT_REF_GUARD_MC;
        end else if (main_tick_q && guard_q != 2'h0) begin
            guard_q <= guard_q - 2'h1;
        end
    end

    // enable history for edge detection of software enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_en_p_q <= 1'b1;
            ext_en_p_q <= 1'b0;
            low_en_p_q <= 1'b0;
            warmup_start_int_q <= 1'b0;
            warmup_start_ext_q <= 1'b0;
            warmup_start_low_q <= 1'b0;
        end else begin
            int_en_p_q <= int_osc_en;
            ext_en_p_q <= ext_osc_en;
            low_en_p_q <= low_osc_en;
            warmup_start_int_q <= int_osc_en & ~int_en_p_q;
            warmup_start_ext_q <= ext_osc_en & ~ext_en_p_q;
            warmup_start_low_q <= low_osc_en & ~low_en_p_q;
        end
    end

    // fault conditions; the check uses the clock actually in use, so a
    // stop before the main switch completes is caught as well
    assign early_stop = (guard_q != 2'h0) &&
        ((~int_osc_en & int_en_p_q) | (~ext_osc_en & ext_en_p_q));
    assign all_stop = !int_osc_en && !ext_osc_en && !low_osc_en;
    assign slow_dead = main_is_slow_q && !low_osc_en;
    assign hf_dead = !main_is_slow_q &&
        !(ref_sel_q ? ext_osc_en : int_osc_en);
    assign pin_bad = ext_osc_en && !port_osc_pin_select;
    assign both_dead = ref_switching_q && !(int_osc_en && ext_osc_en);
    assign fault = early_stop | all_stop | slow_dead | hf_dead |
        pin_bad | both_dead;

    // one registered request, held while the fault lasts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysclk_reset_req_q <= 1'b0;
        end else begin
            sysclk_reset_req_q <= fault;
        end
    end

    // gear: the reserved code is dropped and the old division kept
    assign gear_wr_ok = gear_sel_wr && (gear_sel_wdata != `CGT_GEAR_RSVD);
    assign gear_last_cnt = (gear_sel_q == `CGT_GEAR_DIV1) ?
        `CGT_GEAR_LAST1 : (gear_sel_q == `CGT_GEAR_DIV2) ?
        `CGT_GEAR_LAST2 : `CGT_GEAR_LAST4;
    assign gear_last = (gear_cnt_q == gear_last_cnt);
    assign gear_tick_d = hf_ref_tick_q && gear_last;
    // a new code loads only on a period boundary: never a short period
    assign gear_apply = gear_tick_d && (gear_wait_q == 2'h0) &&
        (gear_pend_q != gear_sel_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gear_pend_q <= `CGT_GEAR_RESET;
            gear_wait_q <= 2'h0;
        end else if (gear_wr_ok) begin
            gear_pend_q <= gear_sel_wdata;
            gear_wait_q <= `CGT_GEAR_SETTLE_MC;
        end else if (main_tick_q && gear_wait_q != 2'h0) begin
            gear_wait_q <= gear_wait_q - 2'h1;
        end
    end

    // gear divider counts reference ticks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gear_sel_q <= `CGT_GEAR_RESET;
            gear_cnt_q <= 2'h0;
            gear_tick_q <= 1'b0;
        end else begin
            gear_tick_q <= gear_tick_d;
            if (hf_ref_tick_q) begin
                gear_cnt_q <= gear_last ? 2'h0 : gear_cnt_q + 2'h1;
            end
            if (gear_apply) begin
                gear_sel_q <= gear_pend_q;
            end
        end
    end

    // low clock divided by four
    assign low_q4_d = low_rise && (low_cnt_q == `CGT_LOW_LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_q <= 2'h0;
        end else if (low_rise) begin
            low_cnt_q <= low_cnt_q + 2'h1;
        end
    end

    // main selector moves on a tick of the new source, so the switch
    // takes a while; the old oscillator must keep running until then
    assign main_tick_d = main_is_slow_q ? low_q4_d : gear_tick_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_is_slow_q <= 1'b0;
            main_tick_q <= 1'b0;
        end else begin
            main_tick_q <= main_tick_d;
            if (!main_is_slow_q && slow_select && low_q4_d) begin
                main_is_slow_q <= 1'b1;
            end else if (main_is_slow_q && !slow_select && gear_tick_d) begin
                main_is_slow_q <= 1'b0;
            end
        end
    end

    // prescaler and stages one to eight from the gear clock; stages nine to 21 from stage eight or low clock over four
    assign fast_run = !main_is_slow_q;
    assign presc_carry = fast_run && gear_tick_d && (&presc_q);
    assign s8_carry = presc_carry && (&divider_q[LOW_STAGES-1:0]);
    assign s9_in = (!stage9_slow_select && !main_is_slow_q) ?
        s8_carry : low_q4_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_q <= '0;
            divider_q <= '0;
        end else if (stop_warm_done) begin
            presc_q <= '0;
            divider_q <= '0;
        end else begin
            if (fast_run && gear_tick_d) begin
                presc_q <= presc_q + 1'b1;
            end
            if (presc_carry) begin
                divider_q[LOW_STAGES-1:0] <=
                    divider_q[LOW_STAGES-1:0] + 1'b1;
            end
            if (s9_in) begin
                divider_q[DIV_STAGES-1:LOW_STAGES] <=
                    divider_q[DIV_STAGES-1:LOW_STAGES] + 1'b1;
            end
        end
    end

    // machine cycle counter; an unsupported length runs as one cycle
    assign len_ok = (instr_len >= `CGT_INSTR_MIN &&
        instr_len <= `CGT_INSTR_SHORT_MAX) ||
        (instr_len == `CGT_INSTR_LONGEST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mc_left_q <= 4'h0;
            instr_last_q <= 1'b0;
        end else begin
            instr_last_q <= main_tick_q && (mc_left_q == 4'h1);
            if (instr_start) begin
                mc_left_q <= len_ok ? instr_len : `CGT_INSTR_MIN;
            end else if (main_tick_q && mc_left_q != 4'h0) begin
                mc_left_q <= mc_left_q - 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ref_end_a: assert property (
        ref_switching_q && new_rise |=> !ref_switching_q)
        else $error("reference switch did not end on new edge");
    ref_pause_a: assert property (pause_q <= 3'h2)
        else $error("reference paused too long in a switch");
    ref_slow_a: assert property (
        slow_select && ref_sel_wr |=> $stable(ref_sel_q))
        else $error("reference select changed in slow mode");
    ref_take_a: assert property (
        ref_sel_wr && !slow_select && !ref_switching_q &&
        ref_sel_wdata != ref_sel_q |=> ref_switching_q &&
        ref_sel_q == $past(ref_sel_wdata))
        else $error("reference select write not taken");
    early_stop_a: assert property (
        guard_q != 2'h0 && ($fell(ext_osc_en) || $fell(int_osc_en))
        |=> sysclk_reset_req_q)
        else $error("early oscillator stop gave no reset");
    pin_reset_a: assert property (
        ext_osc_en && !port_osc_pin_select |=> sysclk_reset_req_q)
        else $error("enable without oscillator pins gave no reset");
    warm_edge_a: assert property (
        warmup_start_ext_q |-> $past(ext_osc_en) && !$past(ext_osc_en, 2))
        else $error("warm-up started without a rising enable");
    gear_settle_a: assert property (
        gear_wr_ok |=> $stable(gear_sel_q) [*2])
        else $error("gear code applied too early");
    gear_div1_a: assert property (
        hf_ref_tick_q && gear_sel_q == `CGT_GEAR_DIV1 &&
        gear_cnt_q == 2'h0 |=> gear_tick_q)
        else $error("undivided gear clock missed a tick");
    main_src_a: assert property (
        main_tick_q && !$past(main_is_slow_q) |-> $past(gear_tick_d))
        else $error("main tick not from gear clock");
    slow_hold_a: assert property (
        main_is_slow_q && $past(main_is_slow_q) && !$past(stop_warm_done)
        |-> $stable(divider_q[LOW_STAGES-1:0]) && $stable(presc_q))
        else $error("low divider stages ran in slow mode");
    div_clear_a: assert property (
        stop_warm_done |=> divider_q == '0 && presc_q == '0)
        else $error("divider not cleared after warm-up end");

    ref_done_c: cover property (ref_switching_q ##[1:50] !ref_switching_q);
    slow_in_c: cover property (!main_is_slow_q ##1 main_is_slow_q);
    gear_chg_c: cover property (gear_apply);
    fault_c: cover property (sysclk_reset_req_q);
endmodule
`default_nettype wire

// ---- clock_gear_and_timing_generator_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(o, e) begin checks_done++; if ((o) !== (e)) begin n_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, o, e); end end
module clock_gear_and_timing_generator_tb_top;
    typedef struct {logic [31:0] exp; int sel;} cgt_note_type;
    logic clk, rst, osc_int_pin, osc_ext_pin, osc_low_pin;
    logic int_osc_en, ext_osc_en, low_osc_en, port_osc_pin_select;
    logic slow_select, stage9_slow_select, ref_sel_wr, ref_sel_wdata;
    logic gear_sel_wr, stop_warm_done, instr_start;
    logic [1:0] gear_sel_wdata;
    logic [3:0] instr_len;
    logic ref_sel_q, ref_switching_q, hf_ref_tick_q, gear_tick_q;
    logic main_tick_q, main_is_slow_q, warmup_start_ext_q;
    logic warmup_start_int_q, warmup_start_low_q;
    logic sysclk_reset_req_q, instr_last_q;
    logic [1:0] gear_sel_q;
    logic [20:0] divider_q;
    logic [31:0] meas;
    logic [31:0] cnt_wu_ext = 32'h0, cnt_wu_int = 32'h0, cnt_wu_low = 32'h0;
    logic [7:0] lo_snap;
    logic [12:0] hi_snap;
    int n_errors, checks_done, k;
    cgt_note_type notes[$];
    cgt_note_type nt;
    logic [1:0] codes[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] kept[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    logic [31:0] divs[4] = '{32'h2, 32'h1, 32'h1, 32'h4};

    cgt_top u_dut (.clk(clk), .rst(rst), .osc_int_pin(osc_int_pin),
        .osc_ext_pin(osc_ext_pin), .osc_low_pin(osc_low_pin),
        .int_osc_en(int_osc_en), .ext_osc_en(ext_osc_en),
        .low_osc_en(low_osc_en), .port_osc_pin_select(port_osc_pin_select),
        .slow_select(slow_select), .stage9_slow_select(stage9_slow_select),
        .ref_sel_wr(ref_sel_wr), .ref_sel_wdata(ref_sel_wdata),
        .gear_sel_wr(gear_sel_wr), .gear_sel_wdata(gear_sel_wdata),
        .stop_warm_done(stop_warm_done), .instr_start(instr_start),
        .instr_len(instr_len), .ref_sel_q(ref_sel_q),
        .ref_switching_q(ref_switching_q), .hf_ref_tick_q(hf_ref_tick_q),
        .gear_sel_q(gear_sel_q), .gear_tick_q(gear_tick_q),
        .main_tick_q(main_tick_q), .main_is_slow_q(main_is_slow_q),
        .divider_q(divider_q), .warmup_start_int_q(warmup_start_int_q),
        .warmup_start_ext_q(warmup_start_ext_q),
        .warmup_start_low_q(warmup_start_low_q),
        .sysclk_reset_req_q(sysclk_reset_req_q),
        .instr_last_q(instr_last_q));

    always #5 clk = ~clk;
    // a disabled oscillator stands low; internal and external periods kept unrelated to clk, low period is 14 clk periods
    always #27 osc_int_pin = int_osc_en ? ~osc_int_pin : 1'b0;
    always #23 osc_ext_pin = ext_osc_en ? ~osc_ext_pin : 1'b0;
    always #70 osc_low_pin = low_osc_en ? ~osc_low_pin : 1'b0;

    // warm-up pulses are one cycle wide, so count them rather than sample
    always @(posedge clk) begin
        if (warmup_start_ext_q === 1'b1) cnt_wu_ext <= cnt_wu_ext + 1;
        if (warmup_start_int_q === 1'b1) cnt_wu_int <= cnt_wu_int + 1;
        if (warmup_start_low_q === 1'b1) cnt_wu_low <= cnt_wu_low + 1;
    end

    function automatic logic [31:0] obs(input int s);
        case (s)
            0: obs = {31'h0, ref_sel_q};
            1: obs = {30'h0, gear_sel_q};
            2: obs = {31'h0, sysclk_reset_req_q};
            3: obs = {31'h0, main_is_slow_q};
            4: obs = {11'h0, divider_q};
            5: obs = cnt_wu_ext;
            7: obs = {31'h0, ref_switching_q};
            8: obs = cnt_wu_int;
            9: obs = cnt_wu_low;
            default: obs = meas;
        endcase
    endfunction

    // monitor: every noted expectation is compared mid-cycle, oldest first
    always @(negedge clk) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            `CHK(obs(nt.sel), nt.exp)
        end
    end

    task note(input logic [31:0] e, input int s);
        notes.push_back('{e, s});
    endtask

    task wcyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task wait_for(input int s, input logic [31:0] v);
        int i;
        i = 0;
        while (obs(s) !== v && i < 400) begin
            wcyc(1);
            i++;
        end
    endtask

    task pulse_ref(input logic d);
        @(posedge clk);
        #1 ref_sel_wr = 1'b1;
        ref_sel_wdata = d;
        wcyc(1);
        ref_sel_wr = 1'b0;
    endtask

    task pulse_gear(input logic [1:0] c);
        @(posedge clk);
        #1 gear_sel_wr = 1'b1;
        gear_sel_wdata = c;
        wcyc(1);
        gear_sel_wr = 1'b0;
    endtask

    // reference ticks between two gear ticks gives the division
    task gear_period;
        int i;
        i = 0;
        meas = 0;
        while (gear_tick_q !== 1'b1 && i < 400) begin
            wcyc(1);
            i++;
        end
        wcyc(1);
        while (gear_tick_q !== 1'b1 && i < 800) begin
            if (hf_ref_tick_q === 1'b1) meas++;
            wcyc(1);
            i++;
        end
    endtask

    // start just after a machine cycle tick so no tick straddles the load
    task run_instr;
        int i;
        logic [3:0] len;
        len = 4'($urandom_range(1, 11));
        if (len == 4'hB) len = 4'hD;
        i = 0;
        while (main_tick_q !== 1'b1 && i < 100) begin
            wcyc(1);
            i++;
        end
        instr_len = len;
        instr_start = 1'b1;
        wcyc(1);
        instr_start = 1'b0;
        meas = 0;
        while (instr_last_q !== 1'b1 && i < 500) begin
            wcyc(1);
            if (main_tick_q === 1'b1) meas++;
            i++;
        end
        note(32'(len), 6);
        wcyc(1);
    endtask

    task tally_and_finish;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #500000;
        n_errors++;
        tally_and_finish;
    end

    initial begin
        clk = 0; rst = 1; osc_int_pin = 0; osc_ext_pin = 0; osc_low_pin = 0;
        int_osc_en = 1; ext_osc_en = 0; low_osc_en = 0;
        port_osc_pin_select = 0; slow_select = 0; stage9_slow_select = 0;
        ref_sel_wr = 0; ref_sel_wdata = 0; gear_sel_wr = 0;
        gear_sel_wdata = 2'h0; stop_warm_done = 0; instr_start = 0;
        instr_len = 4'h1; meas = 0; n_errors = 0;
        checks_done = 0;
        void'($urandom(32'h9cabe812));
        repeat (2) @(posedge clk);
        #1 rst = 0;
        note(0, 0);
        note(0, 1);
        note(0, 2);
        gear_period;
        note(4, 6);
        for (k = 0; k < 3; k++) run_instr;
        // every gear code, the reserved one included, from a table
        for (k = 0; k < 4; k++) begin
            pulse_gear(codes[k]);
            note({30'h0, k == 0 ? 2'h0 : kept[k - 1]}, 1);
            wcyc(150);
            note({30'h0, kept[k]}, 1);
            gear_period;
            gear_period;
            note(divs[k], 6);
            wcyc(1);
        end
        // pins still general purpose while the external enable rises
        ext_osc_en = 1;
        wcyc(3);
        note(1, 2);
        port_osc_pin_select = 1;
        wcyc(20);
        note(0, 2);
        note(1, 5);
        // stopping the old oscillator inside the guard window
        pulse_ref(1);
        int_osc_en = 0;
        // the switch may end at any edge, so look while the stop itself counts
        wcyc(1);
        note(1, 2);
        note(1, 0);
        int_osc_en = 1;
        wcyc(100);
        note(0, 2);
        note(1, 8);
        pulse_ref(0);
        meas = 0;
        while (ref_switching_q === 1'b1 && meas < 40) begin
            wcyc(1);
            meas++;
        end
        meas = (meas > 0 && meas <= 14) ? 32'h1 : 32'h0;
        note(1, 6);
        wcyc(100);
        ext_osc_en = 0;
        wcyc(3);
        note(0, 2);
        note(0, 0);
        // slow mode
        low_osc_en = 1;
        wcyc(60);
        slow_select = 1;
        wait_for(3, 1);
        note(1, 3);
        pulse_ref(1);
        wcyc(2);
        note(0, 0);
        lo_snap = divider_q[7:0];
        hi_snap = divider_q[20:8];
        wcyc(200);
        meas = {31'h0, divider_q[7:0] === lo_snap};
        note(1, 6);
        wcyc(1);
        meas = {31'h0, divider_q[20:8] !== hi_snap};
        note(1, 6);
        wcyc(1);
        low_osc_en = 0;
        wcyc(3);
        note(1, 2);
        low_osc_en = 1;
        wcyc(3);
        note(0, 2);
        note(2, 9);
        slow_select = 0;
        wait_for(3, 0);
        note(0, 3);
        // divider clear at the end of a stop-mode warm-up
        wcyc(300);
        stop_warm_done = 1;
        wcyc(1);
        stop_warm_done = 0;
        wcyc(1);
        note(0, 4);
        int_osc_en = 0;
        wcyc(3);
        note(1, 2);
        int_osc_en = 1;
        wcyc(3);
        note(0, 2);
        wcyc(2);
        tally_and_finish;
    end
endmodule
`default_nettype wire
